// *** gauge_smbus_status_and_info_commands.sv ***
`timescale 1ns/1ps
`include "gauge_cfg.svh"

module gauge_smbus_status_and_info_commands (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic flashRdEn,
    output logic [7:0] flashRdAddr,
    input wire logic [7:0] flashRdData,
    output logic flashWrEn,
    output logic [7:0] flashWrAddr,
    output logic [7:0] flashWrData,
    input wire logic saveReq,
    input wire logic [7:0] saveAddr,
    input wire logic [7:0] saveData,
    input wire logic packInserted,
    input wire logic sealed,
    input wire logic dischargeCycleQualified,
    input wire logic frontEndLinkFailed,
    input wire logic [7:0] permanentFailureCode,
    input wire logic prolongedOverCurrent,
    input wire logic overVoltage,
    input wire logic overTemperature,
    input wire logic overload,
    input wire logic overDischarge,
    input wire logic [15:0] packVoltageMv,
    input wire logic [15:0] cell1Mv,
    input wire logic [15:0] cell2Mv,
    input wire logic [15:0] cell3Mv,
    input wire logic [15:0] cell4Mv,
    input wire logic [15:0] edv2ThresholdMv,
    input wire logic [15:0] pendingEdvMv,
    input wire logic [7:0] frontEndStatus,
    output logic [7:0] packConditionFlags,
    output logic altCellCmdSelect,
    output logic configLoaded
);

gauge_pkg::gauge_state_s s;
gauge_pkg::gauge_state_s n;
logic cmdValid;
logic [7:0] cmdByte;
logic rdStart;
logic txNext;
logic busStop;
logic secondDischargeEndReached;
logic overlimitFaultNow;
logic underlimitFaultNow;
logic [15:0] lowestCellMv;
logic [15:0] selCellMv;
logic [4:0] nextIdx;
logic [7:0] saveOffset;

////////////////////////////////////////////////////////////////////////////////

function automatic logic [15:0] minMv(input logic [15:0] a, input logic [15:0] b);
    minMv = (a < b) ? a : b;
endfunction : minMv

function automatic logic cmdSupported(input logic [7:0] c, input logic alt);
    cmdSupported = (c == `CMD_CHEM) || (c == `CMD_MAKER) || (c == `CMD_PACK)
        || (c[7:2] == (alt ? `CMD_CELL_ALT : `CMD_CELL_STD));
endfunction : cmdSupported

function automatic logic [7:0] respByte(
    input logic [7:0] c,
    input logic [4:0] idx,
    input logic [15:0][7:0] sh,
    input logic [7:0] flags,
    input logic [15:0] cellWord,
    input logic [7:0] afe,
    input logic [15:0] edv,
    input logic alt
);
    logic [7:0] chemLen;
    chemLen = (sh[`IDX_CHEM_LEN] > `CHEM_MAX) ? `CHEM_MAX : sh[`IDX_CHEM_LEN];
    respByte = `FILL_BYTE;
    if (c == `CMD_CHEM) begin
        // Count first, then the stored characters
        if (idx == 5'h00) begin
            respByte = chemLen;
        end else if ({3'h0, idx} <= chemLen) begin
            respByte = sh[idx[3:0]];
        end
    end else if (c == `CMD_MAKER) begin
        if (idx == 5'h00) begin
            respByte = `MAKER_LEN;
        end else if (idx < `MAKER_AFE_IDX) begin
            // Pack cfg, gauge cfg, misc x2, filter, discharge, load, low, near full x2
            respByte = sh[4'(idx + `IDX_MAKER_FIRST)];
        end else if (idx == `MAKER_AFE_IDX) begin
            respByte = afe;
        end else if (idx == `MAKER_EDV_LO_IDX) begin
            respByte = edv[7:0];
        end else if (idx == `MAKER_EDV_HI_IDX) begin
            respByte = edv[15:8];
        end
    end else if (c == `CMD_PACK) begin
        if (idx == 5'h00) begin
            respByte = flags;
        end else if (idx == 5'h01) begin
            respByte = sh[`IDX_PACK_CFG];
        end
    end else if (c[7:2] == (alt ? `CMD_CELL_ALT : `CMD_CELL_STD)) begin
        if (idx == 5'h00) begin
            respByte = cellWord[7:0];
        end else if (idx == 5'h01) begin
            respByte = cellWord[15:8];
        end
    end
endfunction : respByte

////////////////////////////////////////////////////////////////////////////////

smbus_link link (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .cmdAck(s.cmdOk),
    .txByte(s.txByte),
    .cmdValid(cmdValid),
    .cmdByte(cmdByte),
    .rdStart(rdStart),
    .txNext(txNext),
    .busStop(busStop)
);

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    n = s;
    n.wrEn = 1'b0;
    altCellCmdSelect = s.shadow[`IDX_MISC2][`ALT_CELL_BIT];
    lowestCellMv = minMv(minMv(cell1Mv, cell2Mv), minMv(cell3Mv, cell4Mv));
    // Option picks the weakest cell or the whole pack
    secondDischargeEndReached = s.shadow[`IDX_GAUGE_CFG][`EDV_CELL_BIT]
        ? (lowestCellMv <= edv2ThresholdMv)
        : (packVoltageMv <= edv2ThresholdMv);
    overlimitFaultNow = prolongedOverCurrent | overVoltage | overTemperature;
    underlimitFaultNow = overload | overDischarge;
    unique case (s.cmd[1:0])
        2'h0: selCellMv = cell4Mv;
        2'h1: selCellMv = cell3Mv;
        2'h2: selCellMv = cell2Mv;
        2'h3: selCellMv = cell1Mv;
    endcase
    nextIdx = (s.respIdx == 5'h1F) ? s.respIdx : s.respIdx + 5'h01;
    saveOffset = saveAddr - `FLASH_BASE;

    // Stored code 0x66 sets, 0x00 clears, anything else holds
    if (permanentFailureCode == `PF_SET_CODE) begin
        n.permanentFailureSeen = 1'b1;
    end else if (permanentFailureCode == `PF_CLR_CODE) begin
        n.permanentFailureSeen = 1'b0;
    end

    // Bits sampled afresh every cycle; the failure bit copies the latch
    n.packConditionFlags[`FLAG_PACK_INSERTED] = packInserted;
    n.packConditionFlags[`FLAG_EDV] = secondDischargeEndReached;
    n.packConditionFlags[`FLAG_SEAL] = sealed;
    n.packConditionFlags[`FLAG_QUAL] = dischargeCycleQualified;
    n.packConditionFlags[`FLAG_AFE] = frontEndLinkFailed;
    n.packConditionFlags[`FLAG_PF] = n.permanentFailureSeen;
    n.packConditionFlags[`FLAG_OVER] = overlimitFaultNow;
    n.packConditionFlags[`FLAG_UNDER] = underlimitFaultNow;

    unique case (s.mode)
        gauge_pkg::MODE_LOAD: begin
            // One-cycle read latency: data lags the address by one
            if (s.loadCnt != 5'h00) begin
                n.shadow[s.loadCnt[3:0] - 4'h1] = flashRdData;
            end
            n.loadCnt = s.loadCnt + 5'h01;
            n.rdAddr = `FLASH_BASE + {3'h0, s.loadCnt} + 8'h01;
            if (s.loadCnt == `LOAD_DONE) begin
                n.mode = gauge_pkg::MODE_RUN;
            end
        end
        gauge_pkg::MODE_RUN: begin
            if (cmdValid) begin
                n.cmd = cmdByte;
                n.cmdOk = cmdSupported(cmdByte, altCellCmdSelect);
            end else if (busStop) begin
                n.cmdOk = 1'b0;
            end
            if (rdStart) begin
                n.respIdx = 5'h00;
                n.txByte = respByte(s.cmd, 5'h00, s.shadow, s.packConditionFlags,
                    selCellMv, frontEndStatus, pendingEdvMv, altCellCmdSelect);
            end else if (txNext) begin
                n.respIdx = nextIdx;
                n.txByte = respByte(s.cmd, nextIdx, s.shadow, s.packConditionFlags,
                    selCellMv, frontEndStatus, pendingEdvMv, altCellCmdSelect);
            end
        end
    endcase

    // History saves go to flash; shadow kept coherent so reads match
    if (saveReq) begin
        n.wrEn = 1'b1;
        n.wrAddr = saveAddr;
        n.wrData = saveData;
        if (saveOffset < `SHADOW_SPAN) begin
            n.shadow[saveOffset[3:0]] = saveData;
        end
    end
end

always_ff @(posedge mclk) begin
    if (sys_rst) begin
        s <= '0;
        s.mode <= gauge_pkg::MODE_LOAD;
        s.rdAddr <= `FLASH_BASE;
        s.packConditionFlags <= `FLAGS_RST;
    end else begin
        s <= n;
    end
end

////////////////////////////////////////////////////////////////////////////////

// Chemistry bytes feed only respByte: no control path reads them.
assign flashRdEn = (s.mode == gauge_pkg::MODE_LOAD);
assign flashRdAddr = s.rdAddr;
assign flashWrEn = s.wrEn;
assign flashWrAddr = s.wrAddr;
assign flashWrData = s.wrData;
assign packConditionFlags = s.packConditionFlags;
assign configLoaded = (s.mode == gauge_pkg::MODE_RUN);

endmodule : gauge_smbus_status_and_info_commands

// *** gauge_cfg.svh ***
`ifndef GAUGE_CFG_SVH
`define GAUGE_CFG_SVH

// SMBus slave address of a smart battery
`define SLAVE_ADDR 7'h0B

// Command codes
`define CMD_CHEM 8'h22
`define CMD_MAKER 8'h23
`define CMD_PACK 8'h2F
`define CMD_CELL_STD 6'h0F
`define CMD_CELL_ALT 6'h0E

// Shadowed flash window 0x22..0x31
`define FLASH_BASE 8'h22
`define SHADOW_SPAN 8'h10
`define LOAD_DONE 5'h10
`define IDX_CHEM_LEN 4'h0
`define IDX_PACK_CFG 4'h6
`define IDX_GAUGE_CFG 4'h7
`define IDX_MISC2 4'h9
`define IDX_FILTER 4'hA
`define IDX_MAKER_FIRST 5'h05

// Field positions
`define ALT_CELL_BIT 0
`define EDV_CELL_BIT 3
`define FLAG_PACK_INSERTED 7
`define FLAG_EDV 6
`define FLAG_SEAL 5
`define FLAG_QUAL 4
`define FLAG_AFE 3
`define FLAG_PF 2
`define FLAG_OVER 1
`define FLAG_UNDER 0

// Lengths, codes and reset values
`define CHEM_MAX 8'h04
`define MAKER_LEN 8'h0D
`define MAKER_AFE_IDX 5'h0B
`define MAKER_EDV_LO_IDX 5'h0C
`define MAKER_EDV_HI_IDX 5'h0D
`define PF_SET_CODE 8'h66
`define PF_CLR_CODE 8'h00
`define FILL_BYTE 8'hFF
`define FLAGS_RST 8'h00

`endif

// *** gauge_pkg.sv ***
package gauge_pkg;

typedef enum logic [3:0] {
    PH_IDLE = 4'h0,
    PH_ADDR = 4'h1,
    PH_ADDRACK = 4'h2,
    PH_CMD = 4'h3,
    PH_CMDACK = 4'h4,
    PH_TX = 4'h5,
    PH_TXACK = 4'h6,
    PH_TXNEXT = 4'h7,
    PH_WAIT = 4'h8
} link_phase_e;

typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    link_phase_e phase;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic isRead;
    logic drive;
    logic cmdValid;
    logic [7:0] cmdByte;
    logic rdStart;
    logic txNext;
    logic busStop;
} link_state_s;

typedef enum logic {
    MODE_LOAD = 1'b0,
    MODE_RUN = 1'b1
} gauge_mode_e;

typedef struct packed {
    gauge_mode_e mode;
    logic [4:0] loadCnt;
    logic [7:0] rdAddr;
    logic [15:0][7:0] shadow;
    logic [7:0] cmd;
    logic cmdOk;
    logic [4:0] respIdx;
    logic [7:0] txByte;
    logic permanentFailureSeen;
    logic [7:0] packConditionFlags;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
} gauge_state_s;

endpackage : gauge_pkg

// *** smbus_link.sv ***
`timescale 1ns/1ps
`include "gauge_cfg.svh"

module smbus_link (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic cmdAck,
    input wire logic [7:0] txByte,
    output logic cmdValid,
    output logic [7:0] cmdByte,
    output logic rdStart,
    output logic txNext,
    output logic busStop
);

gauge_pkg::link_state_s s;
gauge_pkg::link_state_s n;
logic rise;
logic fall;
logic startCond;
logic stopCond;
logic [7:0] inByte;

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    n = s;
    n.sclMeta = sclIn;
    n.sclSync = s.sclMeta;
    n.sdaMeta = sdaIn;
    n.sdaSync = s.sdaMeta;
    n.sclPrev = s.sclSync;
    n.sdaPrev = s.sdaSync;
    n.cmdValid = 1'b0;
    n.rdStart = 1'b0;
    n.txNext = 1'b0;
    n.busStop = 1'b0;
    rise = s.sclSync & ~s.sclPrev;
    fall = ~s.sclSync & s.sclPrev;
    startCond = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
    stopCond = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
    inByte = {s.shift[6:0], s.sdaSync};
    if (startCond) begin
        // Repeated start also lands here
        n.phase = gauge_pkg::PH_ADDR;
        n.bitCnt = 3'h0;
        n.drive = 1'b0;
    end else if (stopCond) begin
        n.phase = gauge_pkg::PH_IDLE;
        n.drive = 1'b0;
        n.busStop = 1'b1;
    end else begin
        unique case (s.phase)
            gauge_pkg::PH_ADDR, gauge_pkg::PH_CMD: begin
                if (rise) begin
                    n.shift = inByte;
                    n.bitCnt = s.bitCnt + 3'h1;
                    if (s.bitCnt == 3'h7) begin
                        if (s.phase == gauge_pkg::PH_CMD) begin
                            n.cmdValid = 1'b1;
                            n.cmdByte = inByte;
                            n.phase = gauge_pkg::PH_CMDACK;
                        end else if (inByte[7:1] == `SLAVE_ADDR) begin
                            n.isRead = inByte[0];
                            n.rdStart = inByte[0];
                            n.phase = gauge_pkg::PH_ADDRACK;
                        end else begin
                            n.phase = gauge_pkg::PH_WAIT;
                        end
                    end
                end
            end
            gauge_pkg::PH_ADDRACK: begin
                if (fall) begin
                    if (!s.drive) begin
                        n.drive = 1'b1;
                    end else if (s.isRead) begin
                        n.phase = gauge_pkg::PH_TX;
                        n.shift = txByte;
                        n.drive = ~txByte[7];
                        n.bitCnt = 3'h0;
                    end else begin
                        n.phase = gauge_pkg::PH_CMD;
                        n.drive = 1'b0;
                        n.bitCnt = 3'h0;
                    end
                end
            end
            gauge_pkg::PH_CMDACK: begin
                // Refused command: no ack, then ignore until start or stop
                if (fall) begin
                    if (s.drive) begin
                        n.drive = 1'b0;
                        n.phase = gauge_pkg::PH_WAIT;
                    end else if (cmdAck) begin
                        n.drive = 1'b1;
                    end else begin
                        n.phase = gauge_pkg::PH_WAIT;
                    end
                end
            end
            gauge_pkg::PH_TX: begin
                if (fall) begin
                    n.bitCnt = s.bitCnt + 3'h1;
                    if (s.bitCnt == 3'h7) begin
                        n.drive = 1'b0;
                        n.phase = gauge_pkg::PH_TXACK;
                    end else begin
                        n.shift = {s.shift[6:0], 1'b0};
                        n.drive = ~s.shift[6];
                    end
                end
            end
            gauge_pkg::PH_TXACK: begin
                if (rise) begin
                    if (!s.sdaSync) begin
                        n.txNext = 1'b1;
                        n.phase = gauge_pkg::PH_TXNEXT;
                    end else begin
                        n.phase = gauge_pkg::PH_WAIT;
                    end
                end
            end
            gauge_pkg::PH_TXNEXT: begin
                if (fall) begin
                    n.shift = txByte;
                    n.drive = ~txByte[7];
                    n.bitCnt = 3'h0;
                    n.phase = gauge_pkg::PH_TX;
                end
            end
            gauge_pkg::PH_IDLE, gauge_pkg::PH_WAIT: begin
            end
            default: begin
                n.phase = gauge_pkg::PH_IDLE;
                n.drive = 1'b0;
            end
        endcase
    end
end

always_ff @(posedge mclk) begin
    if (sys_rst) begin
        s <= '0;
        // Idle bus is high; starting the history there avoids a false edge
        s.sclMeta <= 1'b1;
        s.sclSync <= 1'b1;
        s.sclPrev <= 1'b1;
        s.sdaMeta <= 1'b1;
        s.sdaSync <= 1'b1;
        s.sdaPrev <= 1'b1;
    end else begin
        s <= n;
    end
end

////////////////////////////////////////////////////////////////////////////////

// Open drain: the pin is only ever pulled low
assign sdaOut = 1'b0;
assign sdaOe = s.drive;
assign cmdValid = s.cmdValid;
assign cmdByte = s.cmdByte;
assign rdStart = s.rdStart;
assign txNext = s.txNext;
assign busStop = s.busStop;

endmodule : smbus_link

// *** gauge_smbus_status_and_info_commands_properties.sv ***
`timescale 1ns/1ps
module gauge_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic saveReq,
    input wire logic [7:0] saveAddr,
    input wire logic [7:0] saveData,
    input wire logic flashWrEn,
    input wire logic [7:0] flashWrAddr,
    input wire logic [7:0] flashWrData,
    input wire logic packInserted,
    input wire logic sealed,
    input wire logic dischargeCycleQualified,
    input wire logic frontEndLinkFailed,
    input wire logic [7:0] permanentFailureCode,
    input wire logic prolongedOverCurrent,
    input wire logic overVoltage,
    input wire logic overTemperature,
    input wire logic overload,
    input wire logic overDischarge,
    input wire logic [7:0] packConditionFlags
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // First edge after reset still shows the cleared byte
    property p_pack_inserted;
        !$past(sys_rst) |-> packConditionFlags[7] == $past(packInserted);
    endproperty
    a_pack_inserted: assert property (p_pack_inserted) else $error("inserted bit wrong");
    property p_seal;
        !$past(sys_rst) |-> packConditionFlags[5] == $past(sealed);
    endproperty
    a_seal: assert property (p_seal) else $error("sealed bit wrong");
    property p_qual;
        $changed(dischargeCycleQualified) |=>
            packConditionFlags[4] == $past(dischargeCycleQualified);
    endproperty
    a_qual: assert property (p_qual) else $error("qualified bit wrong");
    property p_afe;
        frontEndLinkFailed ##1 frontEndLinkFailed |=> packConditionFlags[3];
    endproperty
    a_afe: assert property (p_afe) else $error("link fail bit missing");
    property p_pf;
        !$past(sys_rst) && ($past(permanentFailureCode) inside {8'h66, 8'h00}) |->
            packConditionFlags[2] == ($past(permanentFailureCode) == 8'h66);
    endproperty
    a_pf: assert property (p_pf) else $error("failure bit wrong");
    property p_over;
        !$past(sys_rst) |-> packConditionFlags[1] ==
            ($past(prolongedOverCurrent) | $past(overVoltage) | $past(overTemperature));
    endproperty
    a_over: assert property (p_over) else $error("overlimit bit wrong");
    property p_under;
        (overload || overDischarge) |=> packConditionFlags[0];
    endproperty
    a_under: assert property (p_under) else $error("underlimit bit missing");
    property p_save;
        saveReq |=> flashWrEn && flashWrAddr == $past(saveAddr)
            && flashWrData == $past(saveData);
    endproperty
    a_save: assert property (p_save) else $error("save not written");
    // A stray write would corrupt stored history
    property p_wr_cause;
        flashWrEn |-> $past(saveReq);
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("write without request");
    c_save: cover property (saveReq ##1 flashWrEn);
    c_hold: cover property (packConditionFlags[2] && permanentFailureCode == 8'h12);
    c_mix: cover property (packConditionFlags == 8'hAA);
endmodule : gauge_checker

bind gauge_smbus_status_and_info_commands gauge_checker u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .saveReq(saveReq), .saveAddr(saveAddr),
    .saveData(saveData), .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr),
    .flashWrData(flashWrData), .packInserted(packInserted), .sealed(sealed),
    .dischargeCycleQualified(dischargeCycleQualified),
    .frontEndLinkFailed(frontEndLinkFailed), .permanentFailureCode(permanentFailureCode),
    .prolongedOverCurrent(prolongedOverCurrent), .overVoltage(overVoltage),
    .overTemperature(overTemperature), .overload(overload), .overDischarge(overDischarge),
    .packConditionFlags(packConditionFlags)
);

// *** smbus_host_model.sv ***
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic mclk,
    input wire logic devOe,
    output logic scl,
    output logic sda
);
    logic sdaH = 1'b1;
    logic ok;
    logic [7:0] rx [0:13];
    // Pull-up: a released line reads high
    assign sda = sdaH & ~devOe;
    initial scl = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n
    // Gap after the low edge so data never moves while the synced clock is high
    task automatic bit_x(input logic b, output logic r);
        sdaH = b;
        wait_n(8);
        scl = 1'b1;
        wait_n(4);
        r = sda;
        wait_n(4);
        scl = 1'b0;
        wait_n(2);
    endtask : bit_x
    task automatic start_c();
        sdaH = 1'b1;
        wait_n(4);
        scl = 1'b1;
        wait_n(8);
        sdaH = 1'b0;
        wait_n(8);
        scl = 1'b0;
        wait_n(2);
    endtask : start_c
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic xfer(input logic [7:0] cmd, input int n);
        logic a;
        logic r;
        start_c();
        wr_byte(8'h16, a);
        wr_byte(cmd, ok);
        ok = ok & a;
        if (ok) begin
            start_c();
            wr_byte(8'h17, a);
            for (int k = 0; k < n; k++) begin
                for (int i = 7; i >= 0; i--) begin
                    bit_x(1'b1, rx[k][i]);
                end
                bit_x(k == n - 1, r);
            end
        end
        sdaH = 1'b0;
        wait_n(4);
        scl = 1'b1;
        wait_n(8);
        sdaH = 1'b1;
        wait_n(8);
    endtask : xfer
endmodule : smbus_host_model

// *** gauge_smbus_status_and_info_commands_tb.sv ***
`timescale 1ns/1ps
module gauge_smbus_status_and_info_commands_tb;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic scl, sda, sdaOut, sdaOe, flashRdEn, flashWrEn, configLoaded, altSel;
    logic [7:0] flashRdAddr, flashWrAddr, flashWrData, flags;
    logic [7:0] flashRdData = 8'h00;
    logic saveReq = 1'b0;
    logic [7:0] saveAddr = 8'h00;
    logic [7:0] saveData = 8'h00;
    logic [7:0] pfCode = 8'h00;
    logic [9:0] flagIn = 10'h000;
    logic [15:0] cellV [0:3];
    logic [7:0] fl [0:255];
    int failCount = 0;
    int nCompared = 0;
    int cyc = 0;

    always #12.5 mclk = ~mclk;

    // Flash answers one cycle after the address; the run takes about 23k cycles
    always @(posedge mclk) begin
        flashRdData <= fl[flashRdAddr];
        if (flashWrEn === 1'b1) begin
            fl[flashWrAddr] <= flashWrData;
        end
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failCount++;
            finish_test();
        end
    end

    gauge_smbus_status_and_info_commands u_dut (
        .mclk(mclk), .sys_rst(sysRst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
        .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr), .flashWrData(flashWrData),
        .saveReq(saveReq), .saveAddr(saveAddr), .saveData(saveData),
        .packInserted(flagIn[9]), .sealed(flagIn[7]), .dischargeCycleQualified(flagIn[6]),
        .frontEndLinkFailed(flagIn[5]), .permanentFailureCode(pfCode),
        .prolongedOverCurrent(flagIn[4]), .overVoltage(flagIn[3]),
        .overTemperature(flagIn[2]), .overload(flagIn[1]), .overDischarge(flagIn[0]),
        .packVoltageMv(flagIn[8] ? 16'h0BB8 : 16'h0BB9), .edv2ThresholdMv(16'h0BB8),
        .cell1Mv(cellV[0]), .cell2Mv(cellV[1]), .cell3Mv(cellV[2]), .cell4Mv(cellV[3]),
        .pendingEdvMv(16'hA55A), .frontEndStatus(8'h3C), .packConditionFlags(flags),
        .altCellCmdSelect(altSel), .configLoaded(configLoaded)
    );
    smbus_host_model u_host (.mclk(mclk), .devOe(sdaOe), .scl(scl), .sda(sda));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Stored length is above four, so the count must be clipped
    task automatic t_chem();
        u_host.xfer(8'h22, 6);
        chk(u_host.ok, 1'b1);
        chk(u_host.rx[0], 8'h04);
        for (int i = 1; i < 5; i++) begin
            chk(u_host.rx[i], fl[8'h22 + i]);
        end
        chk(u_host.rx[5], 8'hFF);
    endtask : t_chem
    task automatic t_maker();
        u_host.xfer(8'h23, 14);
        chk(u_host.rx[0], 8'h0D);
        for (int i = 1; i < 11; i++) begin
            chk(u_host.rx[i], fl[8'h27 + i]);
        end
        chk(u_host.rx[11], 8'h3C);
        chk({u_host.rx[13], u_host.rx[12]}, 16'hA55A);
    endtask : t_maker
    task automatic t_flags(input logic [9:0] f, input logic [7:0] pf, input logic [7:0] want);
        @(negedge mclk);
        flagIn = f;
        pfCode = pf;
        repeat (3) @(negedge mclk);
        chk(flags, want);
        u_host.xfer(8'h2F, 2);
        chk({u_host.rx[1], u_host.rx[0]}, {fl[8'h28], want});
    endtask : t_flags
    task automatic t_cells(input logic alt);
        logic [7:0] base;
        logic [7:0] other;
        base = alt ? 8'h38 : 8'h3C;
        other = alt ? 8'h3C : 8'h38;
        chk(altSel, alt);
        for (int i = 0; i < 4; i++) begin
            u_host.xfer(base + 8'(i), 2);
            chk(u_host.ok, 1'b1);
            chk({u_host.rx[1], u_host.rx[0]}, cellV[3 - i]);
            u_host.xfer(other + 8'(i), 2);
            chk(u_host.ok, 1'b0);
        end
    endtask : t_cells
    task automatic t_save(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        saveReq = 1'b1;
        saveAddr = a;
        saveData = d;
        @(negedge mclk);
        saveReq = 1'b0;
        repeat (3) @(negedge mclk);
        chk(fl[a], d);
    endtask : t_save
    // Cell option: pack at threshold no longer counts, weakest cell does
    task automatic t_edv_cell();
        t_save(8'h29, 8'h08);
        t_flags(10'h100, 8'h00, 8'h00);
        cellV[2] = 16'h0BB8;
        t_flags(10'h000, 8'h00, 8'h40);
    endtask : t_edv_cell
    task automatic finish_test();
        if (failCount == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            fl[i] = 8'(i) ^ 8'hC3;
        end
        // Pack voltage drives the threshold bit, not the lowest cell
        fl[8'h29] = 8'h00;
        for (int i = 0; i < 4; i++) begin
            cellV[i] = 16'h0D00 + 16'(i);
        end
        repeat (6) @(negedge mclk);
        sysRst = 1'b0;
        repeat (30) @(negedge mclk);
        chk(configLoaded, 1'b1);
        chk(flashRdEn, 1'b0);
        chk(sdaOut, 1'b0);
        t_chem();
        t_maker();
        t_flags(10'h2A4, 8'h00, 8'hAA);
        t_flags(10'h152, 8'h66, 8'h57);
        t_flags(10'h009, 8'h12, 8'h07);
        t_flags(10'h000, 8'h00, 8'h00);
        u_host.xfer(8'h24, 1);
        chk(u_host.ok, 1'b0);
        t_cells(1'b0);
        t_save(8'h2B, 8'h01);
        t_cells(1'b1);
        t_edv_cell();
        t_maker();
        sysRst = 1'b1;
        repeat (2) @(negedge mclk);
        chk(configLoaded, 1'b0);
        chk(flashRdAddr, 8'h22);
        sysRst = 1'b0;
        repeat (30) @(negedge mclk);
        chk(altSel, 1'b1);
        finish_test();
    end
endmodule : gauge_smbus_status_and_info_commands_tb
